// File: logic/output_dependency_select_pkg.sv
// constants for the output dependency selection block
package output_dependency_select_pkg;

  // ------------------------------------------------------------
  // register port geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int REG_COUNT = 9;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_OUT6_ANALOG_DEPS = 8'h2b;
  localparam logic [7:0] ADDR_OUT6_LOGIC_DEPS_LOW = 8'h2c;
  localparam logic [7:0] ADDR_OUT6_LOGIC_DEPS_HIGH = 8'h2d;
  localparam logic [7:0] ADDR_OUT6_EIGHTH_DEP = 8'h31;
  localparam logic [7:0] ADDR_OUT7_ANALOG_DEPS = 8'h32;
  localparam logic [7:0] ADDR_OUT7_LOGIC_DEPS_LOW = 8'h33;
  localparam logic [7:0] ADDR_OUT7_LOGIC_DEPS_HIGH = 8'h34;
  localparam logic [7:0] ADDR_OUT7_EIGHTH_DEP = 8'h35;
  localparam logic [7:0] ADDR_MANUAL_RESET_DEP_MASK = 8'h40;

  // index of each register in the storage array
  localparam int IDX_OUT6_ANALOG = 0;
  localparam int IDX_OUT6_LOW = 1;
  localparam int IDX_OUT6_HIGH = 2;
  localparam int IDX_OUT6_EIGHTH = 3;
  localparam int IDX_OUT7_ANALOG = 4;
  localparam int IDX_OUT7_LOW = 5;
  localparam int IDX_OUT7_HIGH = 6;
  localparam int IDX_OUT7_EIGHTH = 7;
  localparam int IDX_MR_MASK = 8;

  localparam logic [7:0] REG_ADDR [REG_COUNT] = '{
    ADDR_OUT6_ANALOG_DEPS, ADDR_OUT6_LOGIC_DEPS_LOW, ADDR_OUT6_LOGIC_DEPS_HIGH,
    ADDR_OUT6_EIGHTH_DEP, ADDR_OUT7_ANALOG_DEPS, ADDR_OUT7_LOGIC_DEPS_LOW,
    ADDR_OUT7_LOGIC_DEPS_HIGH, ADDR_OUT7_EIGHTH_DEP, ADDR_MANUAL_RESET_DEP_MASK};

  // factory default of every dependency register
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int MON_COUNT = 6;
  localparam int MON_SMALL_COUNT = 4;
  localparam int WD_BIT = 6;
  localparam int GPI_LOW_LSB = 6;
  localparam int GPI_HIGH_LSB = 0;
  localparam int GPI_COUNT = 4;
  localparam int PEER_LSB = 2;
  localparam int PEER_SLOTS = 6;
  localparam int PEER_SMALL_FIRST = 2;
  localparam int EIGHTH_BIT = 0;
  localparam int TIMEOUT_LSB = 1;
  localparam int TIMEOUT_W = 3;
  localparam int MR_OUT6_BIT = 5;
  localparam int MR_OUT7_BIT = 6;

  // ------------------------------------------------------------
  // layout of the combined source vector
  // ------------------------------------------------------------
  localparam int SRC_MON = 0;
  localparam int SRC_WD = 6;
  localparam int SRC_GPI = 7;
  localparam int SRC_PEER = 11;
  localparam int SRC_EIGHTH = 17;
  localparam int SRC_MR = 18;
  localparam int SRC_COUNT = 19;

  // peer output numbers (zero based) per slot, per variant
  localparam int PEER_COUNT = 8;
  localparam int EIGHTH_PEER = 7;
  localparam int OUT6_PEER_LARGE [PEER_SLOTS] = '{0, 1, 2, 3, 4, 6};
  localparam int OUT6_PEER_SMALL [PEER_SLOTS] = '{0, 0, 0, 1, 2, 4};
  localparam int OUT7_PEER_LARGE [PEER_SLOTS] = '{0, 1, 2, 3, 4, 5};
  localparam int OUT7_PEER_SMALL [PEER_SLOTS] = '{0, 0, 0, 1, 2, 3};

endpackage

// File: logic/dep_or_combiner.sv
// and-or reduction of enabled dependency sources
`timescale 1ns/1ps
`default_nettype none

module dep_or_combiner #(
  parameter int WIDTH = 19
) (
  input wire logic [WIDTH-1:0] enable_i,
  input wire logic [WIDTH-1:0] source_i,
  output logic hit_o
);

  logic [WIDTH-1:0] hits;

  // ------------------------------------------------------------
  // per source gating
  // ------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < WIDTH; k++)
    begin : g_src
      // a cleared enable blocks the source entirely
      assign hits[k] = enable_i[k] & source_i[k];
    end
  endgenerate

  assign hit_o = |hits;

endmodule // dep_or_combiner

`default_nettype wire

// File: logic/output_dependency_select.sv
// dependency selection for the sixth and seventh programmable outputs
`timescale 1ns/1ps
`default_nettype none

module output_dependency_select #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [output_dependency_select_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [output_dependency_select_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [output_dependency_select_pkg::MON_COUNT-1:0] monitor_input_uv_i,
  input wire logic watchdog_fault_i,
  input wire logic [output_dependency_select_pkg::GPI_COUNT-1:0] logic_input_i,
  input wire logic manual_reset_input_b_i,
  input wire logic [output_dependency_select_pkg::PEER_COUNT-1:0] prog_output_assert_i,
  output logic [output_dependency_select_pkg::DATA_W-1:0] reg_rdata_o,
  output logic prog_output_six_assert_o,
  output logic prog_output_seven_assert_o,
  output logic [output_dependency_select_pkg::TIMEOUT_W-1:0] prog_output_six_timeout_sel_o,
  output logic [output_dependency_select_pkg::TIMEOUT_W-1:0] prog_output_seven_timeout_sel_o
);

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [output_dependency_select_pkg::DATA_W-1:0] regs [output_dependency_select_pkg::REG_COUNT];
  logic [output_dependency_select_pkg::DATA_W-1:0] out6_analog_deps;
  logic [output_dependency_select_pkg::DATA_W-1:0] out6_logic_deps_low;
  logic [output_dependency_select_pkg::DATA_W-1:0] out6_logic_deps_high;
  logic [output_dependency_select_pkg::DATA_W-1:0] out6_eighth_dep;
  logic [output_dependency_select_pkg::DATA_W-1:0] out7_analog_deps;
  logic [output_dependency_select_pkg::DATA_W-1:0] out7_logic_deps_low;
  logic [output_dependency_select_pkg::DATA_W-1:0] out7_logic_deps_high;
  logic [output_dependency_select_pkg::DATA_W-1:0] out7_eighth_dep;
  logic [output_dependency_select_pkg::DATA_W-1:0] manual_reset_dep_mask;

  // mixed registers keep every bit so neighbouring fields read back intact
  genvar r;
  generate
    for (r = 0; r < output_dependency_select_pkg::REG_COUNT; r++)
    begin : g_reg
      always_ff @(posedge clk_i)
      begin
        if (!rst_b_i)
        begin
          regs[r] <= output_dependency_select_pkg::REG_RESET;
        end
        else if (reg_we_i && reg_addr_i == output_dependency_select_pkg::REG_ADDR[r])
        begin
          // reserved bits are stored as written and ignored below
          regs[r] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  assign out6_analog_deps = regs[output_dependency_select_pkg::IDX_OUT6_ANALOG];
  assign out6_logic_deps_low = regs[output_dependency_select_pkg::IDX_OUT6_LOW];
  assign out6_logic_deps_high = regs[output_dependency_select_pkg::IDX_OUT6_HIGH];
  assign out6_eighth_dep = regs[output_dependency_select_pkg::IDX_OUT6_EIGHTH];
  assign out7_analog_deps = regs[output_dependency_select_pkg::IDX_OUT7_ANALOG];
  assign out7_logic_deps_low = regs[output_dependency_select_pkg::IDX_OUT7_LOW];
  assign out7_logic_deps_high = regs[output_dependency_select_pkg::IDX_OUT7_HIGH];
  assign out7_eighth_dep = regs[output_dependency_select_pkg::IDX_OUT7_EIGHTH];
  assign manual_reset_dep_mask = regs[output_dependency_select_pkg::IDX_MR_MASK];

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  logic [output_dependency_select_pkg::DATA_W-1:0] next_rdata;

  always_comb
  begin
    next_rdata = output_dependency_select_pkg::UNMAPPED_READ;
    for (int i = 0; i < output_dependency_select_pkg::REG_COUNT; i++)
    begin
      if (reg_addr_i == output_dependency_select_pkg::REG_ADDR[i])
      begin
        next_rdata = regs[i];
      end
    end
  end

  // read data holds until the next read strobe
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      reg_rdata_o <= output_dependency_select_pkg::UNMAPPED_READ;
    end
    else if (reg_re_i)
    begin
      reg_rdata_o <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // variant masks
  // ------------------------------------------------------------
  // on the smaller part the larger-only bits are forced off even if software
  // leaves them set, so a stale image cannot pull in nonexistent sources
  logic [output_dependency_select_pkg::MON_COUNT-1:0] mon_avail;
  logic [output_dependency_select_pkg::PEER_SLOTS-1:0] peer_avail;
  logic eighth_avail;

  genvar m;
  generate
    for (m = 0; m < output_dependency_select_pkg::MON_COUNT; m++)
    begin : g_mon_avail
      assign mon_avail[m] = LARGE_VARIANT || (m < output_dependency_select_pkg::MON_SMALL_COUNT);
    end
    for (m = 0; m < output_dependency_select_pkg::PEER_SLOTS; m++)
    begin : g_peer_avail
      assign peer_avail[m] = LARGE_VARIANT || (m >= output_dependency_select_pkg::PEER_SMALL_FIRST);
    end
  endgenerate

  assign eighth_avail = LARGE_VARIANT;

  // ------------------------------------------------------------
  // enable vectors
  // ------------------------------------------------------------
  logic [output_dependency_select_pkg::SRC_COUNT-1:0] out6_enable;
  logic [output_dependency_select_pkg::SRC_COUNT-1:0] out7_enable;

  // output six enables
  assign out6_enable[output_dependency_select_pkg::SRC_MON +: output_dependency_select_pkg::MON_COUNT] =
    out6_analog_deps[output_dependency_select_pkg::MON_COUNT-1:0] & mon_avail;
  assign out6_enable[output_dependency_select_pkg::SRC_WD] =
    out6_analog_deps[output_dependency_select_pkg::WD_BIT];
  assign out6_enable[output_dependency_select_pkg::SRC_GPI +: 2] =
    out6_logic_deps_low[output_dependency_select_pkg::GPI_LOW_LSB +: 2];
  assign out6_enable[output_dependency_select_pkg::SRC_GPI + 2 +: 2] =
    out6_logic_deps_high[output_dependency_select_pkg::GPI_HIGH_LSB +: 2];
  assign out6_enable[output_dependency_select_pkg::SRC_PEER +: output_dependency_select_pkg::PEER_SLOTS] =
    out6_logic_deps_high[output_dependency_select_pkg::PEER_LSB +: output_dependency_select_pkg::PEER_SLOTS]
    & peer_avail;
  assign out6_enable[output_dependency_select_pkg::SRC_EIGHTH] =
    out6_eighth_dep[output_dependency_select_pkg::EIGHTH_BIT] & eighth_avail;
  assign out6_enable[output_dependency_select_pkg::SRC_MR] =
    manual_reset_dep_mask[output_dependency_select_pkg::MR_OUT6_BIT];

  // output seven enables
  assign out7_enable[output_dependency_select_pkg::SRC_MON +: output_dependency_select_pkg::MON_COUNT] =
    out7_analog_deps[output_dependency_select_pkg::MON_COUNT-1:0] & mon_avail;
  assign out7_enable[output_dependency_select_pkg::SRC_WD] =
    out7_analog_deps[output_dependency_select_pkg::WD_BIT];
  assign out7_enable[output_dependency_select_pkg::SRC_GPI +: 2] =
    out7_logic_deps_low[output_dependency_select_pkg::GPI_LOW_LSB +: 2];
  assign out7_enable[output_dependency_select_pkg::SRC_GPI + 2 +: 2] =
    out7_logic_deps_high[output_dependency_select_pkg::GPI_HIGH_LSB +: 2];
  assign out7_enable[output_dependency_select_pkg::SRC_PEER +: output_dependency_select_pkg::PEER_SLOTS] =
    out7_logic_deps_high[output_dependency_select_pkg::PEER_LSB +: output_dependency_select_pkg::PEER_SLOTS]
    & peer_avail;
  assign out7_enable[output_dependency_select_pkg::SRC_EIGHTH] =
    out7_eighth_dep[output_dependency_select_pkg::EIGHTH_BIT] & eighth_avail;
  assign out7_enable[output_dependency_select_pkg::SRC_MR] =
    manual_reset_dep_mask[output_dependency_select_pkg::MR_OUT7_BIT];

  // ------------------------------------------------------------
  // source vectors
  // ------------------------------------------------------------
  logic [output_dependency_select_pkg::SRC_COUNT-1:0] out6_source;
  logic [output_dependency_select_pkg::SRC_COUNT-1:0] out7_source;
  logic [output_dependency_select_pkg::PEER_SLOTS-1:0] out6_peer;
  logic [output_dependency_select_pkg::PEER_SLOTS-1:0] out7_peer;

  // slot to output numbering differs between variants
  genvar p;
  generate
    for (p = 0; p < output_dependency_select_pkg::PEER_SLOTS; p++)
    begin : g_peer
      if (LARGE_VARIANT)
      begin : g_large
        assign out6_peer[p] = prog_output_assert_i[output_dependency_select_pkg::OUT6_PEER_LARGE[p]];
        assign out7_peer[p] = prog_output_assert_i[output_dependency_select_pkg::OUT7_PEER_LARGE[p]];
      end
      else
      begin : g_small
        assign out6_peer[p] = prog_output_assert_i[output_dependency_select_pkg::OUT6_PEER_SMALL[p]];
        assign out7_peer[p] = prog_output_assert_i[output_dependency_select_pkg::OUT7_PEER_SMALL[p]];
      end
    end
  endgenerate

  assign out6_source = {
    ~manual_reset_input_b_i,
    prog_output_assert_i[output_dependency_select_pkg::EIGHTH_PEER],
    out6_peer,
    logic_input_i,
    watchdog_fault_i,
    monitor_input_uv_i};

  assign out7_source = {
    ~manual_reset_input_b_i,
    prog_output_assert_i[output_dependency_select_pkg::EIGHTH_PEER],
    out7_peer,
    logic_input_i,
    watchdog_fault_i,
    monitor_input_uv_i};

  // ------------------------------------------------------------
  // combine and register
  // ------------------------------------------------------------
  logic next_out6_assert;
  logic next_out7_assert;

  dep_or_combiner #(
    .WIDTH(output_dependency_select_pkg::SRC_COUNT)
  ) u_out6_comb (
    .enable_i(out6_enable),
    .source_i(out6_source),
    .hit_o(next_out6_assert)
  );

  dep_or_combiner #(
    .WIDTH(output_dependency_select_pkg::SRC_COUNT)
  ) u_out7_comb (
    .enable_i(out7_enable),
    .source_i(out7_source),
    .hit_o(next_out7_assert)
  );

  // one cycle of latency buys glitch-free outputs toward the delay stage
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      prog_output_six_assert_o <= 1'b0;
    end
    else
    begin
      prog_output_six_assert_o <= next_out6_assert;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      prog_output_seven_assert_o <= 1'b0;
    end
    else
    begin
      prog_output_seven_assert_o <= next_out7_assert;
    end
  end

  // timeout codes share the eighth-dependency registers
  assign prog_output_six_timeout_sel_o =
    out6_eighth_dep[output_dependency_select_pkg::TIMEOUT_LSB +: output_dependency_select_pkg::TIMEOUT_W];
  assign prog_output_seven_timeout_sel_o =
    out7_eighth_dep[output_dependency_select_pkg::TIMEOUT_LSB +: output_dependency_select_pkg::TIMEOUT_W];

endmodule // output_dependency_select

`default_nettype wire

// File: testbench/supply_side_model.sv
// behavioural model of the supply side lines that feed the dependency logic
`timescale 1ns/1ps
`default_nettype none
module supply_side_model (
  input wire logic [19:0] lines_i,
  output logic [5:0] monitor_input_uv_o,
  output logic watchdog_fault_o,
  output logic [3:0] logic_input_o,
  output logic [7:0] prog_output_assert_o,
  output logic manual_reset_input_b_o
);
  // ------------------------------------------------------------
  // line map: 0-5 monitors, 6 watchdog, 7-10 logic, 11-18 outputs, 19 push button
  // ------------------------------------------------------------
  assign monitor_input_uv_o = lines_i[5:0];
  assign watchdog_fault_o = lines_i[6];
  assign logic_input_o = lines_i[10:7];
  assign prog_output_assert_o = lines_i[18:11];
  // the push button pin is active low, so a request pulls it down
  assign manual_reset_input_b_o = ~lines_i[19];
endmodule // supply_side_model
`default_nettype wire

// File: testbench/output_dependency_select_monitor.sv
// assertion checker for the output dependency selection block
`timescale 1ns/1ps
`default_nettype none
module output_dependency_select_monitor #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [5:0] monitor_input_uv_i,
  input wire logic watchdog_fault_i,
  input wire logic [3:0] logic_input_i,
  input wire logic manual_reset_input_b_i,
  input wire logic [7:0] prog_output_assert_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic prog_output_six_assert_o,
  input wire logic prog_output_seven_assert_o,
  input wire logic [2:0] prog_output_six_timeout_sel_o,
  input wire logic [2:0] prog_output_seven_timeout_sel_o
);
  // ------------------------------------------------------------
  // shadow registers and expected assert requests
  // ------------------------------------------------------------
  logic [7:0] shadow [9];
  logic [7:0] rd_val;
  logic hit;
  logic exp_six;
  logic exp_seven;
  int idx;

  function automatic logic merged(input logic [7:0] an, input logic [7:0] lo, input logic [7:0] hi,
                                  input logic [7:0] ei, input logic mr, input bit sev);
    logic [18:0] en;
    logic [18:0] src;
    int map;
    en = {mr, ei[0], hi, lo[7:6], an[6:0]};
    if (!LARGE_VARIANT)
      en = en & ~19'h21830;
    src = {~manual_reset_input_b_i, prog_output_assert_i[7], 6'h00, logic_input_i, watchdog_fault_i,
           monitor_input_uv_i};
    for (int j = 0; j < 6; j++)
    begin
      map = sev ? (LARGE_VARIANT ? output_dependency_select_pkg::OUT7_PEER_LARGE[j]
                                 : output_dependency_select_pkg::OUT7_PEER_SMALL[j])
                : (LARGE_VARIANT ? output_dependency_select_pkg::OUT6_PEER_LARGE[j]
                                 : output_dependency_select_pkg::OUT6_PEER_SMALL[j]);
      src[11 + j] = prog_output_assert_i[map];
    end
    return |(en & src);
  endfunction

  always_comb
  begin
    hit = 1'b0;
    idx = 0;
    for (int i = 0; i < 9; i++)
      if (reg_addr_i == output_dependency_select_pkg::REG_ADDR[i])
      begin
        hit = 1'b1;
        idx = i;
      end
    rd_val = hit ? shadow[idx] : 8'h00;
    exp_six = merged(shadow[0], shadow[1], shadow[2], shadow[3], shadow[8][5], 1'b0);
    exp_seven = merged(shadow[4], shadow[5], shadow[6], shadow[7], shadow[8][6], 1'b1);
  end

  always_ff @(posedge clk_i)
    if (!rst_b_i)
      shadow <= '{default: 8'h00};
    else if (reg_we_i && hit)
      shadow[idx] <= reg_wdata_i;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_six_sources: assert property (1'b1 |=> prog_output_six_assert_o == $past(exp_six))
    else $error("output six differs from its enabled sources");
  a_seven_sources: assert property (1'b1 |=> prog_output_seven_assert_o == $past(exp_seven))
    else $error("output seven differs from its enabled sources");
  a_button_six: assert property (shadow[8][5] && !manual_reset_input_b_i |=> prog_output_six_assert_o)
    else $error("output six ignores the push button");
  a_button_seven: assert property ($fell(manual_reset_input_b_i) && shadow[8][6] |=> prog_output_seven_assert_o)
    else $error("output seven ignores the push button");
  a_dog_seven: assert property (shadow[4][6] && watchdog_fault_i |=> prog_output_seven_assert_o)
    else $error("output seven ignores the watchdog");
  a_reset_clears: assert property (disable iff (1'b0) !rst_b_i |=> !prog_output_six_assert_o
    && !prog_output_seven_assert_o && reg_rdata_o == 8'h00)
    else $error("reset left an output set");
  a_read_back: assert property (reg_re_i |=> reg_rdata_o == $past(rd_val))
    else $error("read data differs from stored value");
  a_unmapped_zero: assert property (reg_re_i && !hit |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_re_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_timeout_fields: assert property (1'b1 |-> prog_output_six_timeout_sel_o == shadow[3][3:1]
    && prog_output_seven_timeout_sel_o == shadow[7][3:1])
    else $error("timeout select differs from register");

  c_six_up: cover property ($rose(prog_output_six_assert_o));
  c_seven_up: cover property ($rose(prog_output_seven_assert_o));
  c_unmapped: cover property (reg_re_i && !hit);
  c_button: cover property (!manual_reset_input_b_i && prog_output_six_assert_o);
endmodule // output_dependency_select_monitor

bind output_dependency_select output_dependency_select_monitor #(.LARGE_VARIANT(LARGE_VARIANT)) monitor_i (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .monitor_input_uv_i(monitor_input_uv_i),
  .watchdog_fault_i(watchdog_fault_i), .logic_input_i(logic_input_i),
  .manual_reset_input_b_i(manual_reset_input_b_i), .prog_output_assert_i(prog_output_assert_i),
  .reg_rdata_o(reg_rdata_o), .prog_output_six_assert_o(prog_output_six_assert_o),
  .prog_output_seven_assert_o(prog_output_seven_assert_o),
  .prog_output_six_timeout_sel_o(prog_output_six_timeout_sel_o),
  .prog_output_seven_timeout_sel_o(prog_output_seven_timeout_sel_o));
`default_nettype wire

// File: testbench/output_dependency_select_tb.sv
// self-checking bench for the output dependency selection block
`timescale 1ns/1ps
`default_nettype none
module output_dependency_select_tb;
  // ------------------------------------------------------------
  // signals, instances, clock
  // ------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [19:0] lines = 20'h00000;
  logic [5:0] mon;
  logic [3:0] gpi;
  logic [7:0] peer;
  logic [7:0] rdata;
  logic [2:0] tmo6;
  logic [2:0] tmo7;
  logic wd;
  logic mr_b;
  logic six;
  logic seven;
  logic six_s;
  logic seven_s;
  int fails = 0;
  int num_checks = 0;

  supply_side_model far_side (.lines_i(lines), .monitor_input_uv_o(mon), .watchdog_fault_o(wd),
    .logic_input_o(gpi), .prog_output_assert_o(peer), .manual_reset_input_b_o(mr_b));
  output_dependency_select uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .monitor_input_uv_i(mon), .watchdog_fault_i(wd), .logic_input_i(gpi),
    .manual_reset_input_b_i(mr_b), .prog_output_assert_i(peer), .reg_rdata_o(rdata),
    .prog_output_six_assert_o(six), .prog_output_seven_assert_o(seven),
    .prog_output_six_timeout_sel_o(tmo6), .prog_output_seven_timeout_sel_o(tmo7));
  // the smaller part shares every input so one stimulus exercises both numberings
  output_dependency_select #(.LARGE_VARIANT(1'b0)) uut_small (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .monitor_input_uv_i(mon),
    .watchdog_fault_i(wd), .logic_input_i(gpi), .manual_reset_input_b_i(mr_b), .prog_output_assert_i(peer),
    .reg_rdata_o(), .prog_output_six_assert_o(six_s), .prog_output_seven_assert_o(seven_s),
    .prog_output_six_timeout_sel_o(), .prog_output_seven_timeout_sel_o());

  initial
    forever #25 clk_i = ~clk_i;

  // ------------------------------------------------------------
  // shared tasks and scenarios
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // each access leaves one idle edge so a strobe is never lowered and raised in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(posedge clk_i);
    #1 we = 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    re = 1'b1;
    @(posedge clk_i);
    #1 re = 1'b0;
    check(rdata, exp);
    @(posedge clk_i);
    #1;
  endtask

  // one edge of latency from source to output
  task automatic drive(input logic [19:0] v);
    lines = v;
    @(posedge clk_i);
    #1;
  endtask

  task automatic look(input logic sel7, input logic e);
    check({7'h00, sel7 ? seven : six}, {7'h00, e});
  endtask

  task automatic duo(input logic sel7, input logic e_large, input logic e_small);
    look(sel7, e_large);
    check({7'h00, sel7 ? seven_s : six_s}, {7'h00, e_small});
  endtask

  task automatic test_regs();
    for (int i = 0; i < 9; i++)
      rd(output_dependency_select_pkg::REG_ADDR[i], 8'h00);
    for (int i = 0; i < 9; i++)
      wr(output_dependency_select_pkg::REG_ADDR[i], 8'h5a ^ i[7:0]);
    wr(8'h30, 8'hff);
    for (int i = 0; i < 9; i++)
      rd(output_dependency_select_pkg::REG_ADDR[i], 8'h5a ^ i[7:0]);
    rd(8'h30, 8'h00);
    check({2'b00, tmo6, tmo7}, 8'h26);
    rst_b_i = 1'b0;
    @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    for (int i = 0; i < 9; i++)
      rd(output_dependency_select_pkg::REG_ADDR[i], 8'h00);
    $display("test registers done");
  endtask

  // every dependency bit alone: all lines on asserts, its own line off releases
  task automatic test_sources();
    logic [7:0] a;
    int b;
    int ln;
    for (int o = 0; o < 2; o++)
      for (int k = 0; k < 19; k++)
      begin
        a = (k > 17) ? 8'h40 : output_dependency_select_pkg::REG_ADDR[4 * o + (k > 6) + (k > 8) + (k > 16)];
        b = (k < 7) ? k : (k < 9) ? k - 1 : (k < 17) ? k - 9 : (k < 18) ? 0 : 5 + o;
        ln = (k == 16 && o == 0) ? 17 : (k > 16) ? k + 1 : k;
        wr(a, 8'h01 << b);
        drive(20'hfffff);
        look(o[0], 1'b1);
        look(!o[0], 1'b0);
        drive(~(20'h00001 << ln));
        look(o[0], 1'b0);
        wr(a, 8'h00);
        drive(20'h00000);
      end
    $display("test sources done");
  endtask

  // larger-only bits stay dead on the smaller part, shared slots follow its numbering
  task automatic test_small();
    wr(8'h2b, 8'h30);
    wr(8'h32, 8'h30);
    drive(20'h00030);
    duo(1'b0, 1'b1, 1'b0);
    duo(1'b1, 1'b1, 1'b0);
    wr(8'h2b, 8'h00);
    wr(8'h32, 8'h00);
    wr(8'h2d, 8'h0c);
    wr(8'h34, 8'h0c);
    drive(20'h01800);
    duo(1'b0, 1'b1, 1'b0);
    duo(1'b1, 1'b1, 1'b0);
    wr(8'h2d, 8'h10);
    wr(8'h34, 8'h80);
    drive(20'h04800);
    duo(1'b0, 1'b0, 1'b1);
    duo(1'b1, 1'b0, 1'b1);
    wr(8'h2d, 8'h00);
    wr(8'h34, 8'h00);
    wr(8'h31, 8'h01);
    wr(8'h35, 8'h01);
    drive(20'h40000);
    duo(1'b0, 1'b1, 1'b0);
    duo(1'b1, 1'b1, 1'b0);
    wr(8'h31, 8'h00);
    wr(8'h35, 8'h00);
    drive(20'h00000);
    $display("test small variant done");
  endtask

  task automatic test_reserved();
    wr(8'h2b, 8'h80);
    wr(8'h2c, 8'h3f);
    wr(8'h32, 8'h80);
    wr(8'h33, 8'h3f);
    drive(20'hfffff);
    look(1'b0, 1'b0);
    look(1'b1, 1'b0);
    wr(8'h2b, 8'h41);
    drive(20'h00040);
    look(1'b0, 1'b1);
    drive(20'h00001);
    look(1'b0, 1'b1);
    drive(20'h0003e);
    look(1'b0, 1'b0);
    $display("test reserved done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #200000;
    fails++;
    close_out();
  end

  initial
  begin
    repeat (8) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    test_regs();
    test_sources();
    test_small();
    test_reserved();
    close_out();
  end
endmodule // output_dependency_select_tb
`default_nettype wire
